// ==== switch_route_pkg.sv ====
// constants and types shared by the request route decoder
package switch_route_pkg;

  // ----------------------------------------
  // register map, per port stride 0x20
  // ----------------------------------------
  localparam logic [2:0] REG_MEM_BASE  = 3'h0;
  localparam logic [2:0] REG_MEM_LIMIT = 3'h1;
  localparam logic [2:0] REG_IO_RANGE  = 3'h2;
  localparam logic [2:0] REG_BUS       = 3'h3;
  localparam logic [2:0] REG_CTRL      = 3'h4;
  localparam logic [2:0] REG_STATUS    = 3'h5;
  localparam int         PORT_SHIFT    = 5;
  localparam int         REG_SHIFT     = 2;

  // ----------------------------------------
  // control word fields
  // ----------------------------------------
  localparam int CTL_MEM_EN    = 0;
  localparam int CTL_IO_EN     = 1;
  localparam int CTL_MASTER_EN = 2;
  localparam int CTL_DECODE_EN = 3;
  localparam int CTL_MA_MODE   = 4;
  localparam int CTL_SERR_EN   = 5;
  localparam int CTL_FLOOD     = 6;
  localparam int CTL_FATAL     = 7;
  localparam int CTL_NONFATAL  = 8;
  localparam int CTL_HOST_HIDE = 9;
  localparam int CTL_UP_CFG    = 10;
  localparam int CTL_ISA_EN    = 11;
  localparam int CTL_VGA_EN    = 12;
  localparam int CTL_PRIMARY   = 13;
  localparam int CTL_DEF_LSB   = 14;
  localparam int CTL_UNIT_LSB  = 18;
  localparam int CTL_DEV_LSB   = 23;

  // ----------------------------------------
  // status word fields, write one to clear
  // ----------------------------------------
  localparam int STA_DET_MA     = 0;
  localparam int STA_SIG_TA     = 1;
  localparam int STA_SIG_SE     = 2;
  localparam int STA_SEC_DET_MA = 3;
  localparam int STA_SEC_SIG_TA = 4;
  localparam int STA_CHAIN_END  = 5;
  localparam int STA_WIDTH      = 6;

  // ----------------------------------------
  // reset values and fixed windows
  // ----------------------------------------
  localparam logic [31:0] RST_MEM_BASE  = 32'hffffffff;
  localparam logic [31:0] RST_MEM_LIMIT = 32'h00000000;
  localparam logic [31:0] RST_IO_RANGE  = 32'h0000ffff;
  localparam logic [31:0] RST_BUS       = 32'h00000000;
  localparam logic [31:0] RST_CTRL      = 32'h00000000;
  localparam logic [31:0] VGA_MEM_LO    = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_HI    = 32'h000bffff;
  localparam logic [15:0] VGA_IO_LO     = 16'h03b0;
  localparam logic [15:0] VGA_IO_HI     = 16'h03df;
  localparam logic [31:0] ALL_ONES      = 32'hffffffff;

  // ----------------------------------------
  // request kinds and routing actions
  // ----------------------------------------
  typedef enum logic [2:0] {
    KIND_MEM, KIND_IO, KIND_CFG0, KIND_CFG1, KIND_MSG0, KIND_INTR, KIND_SMGT
  } kind_t;

  typedef enum logic [2:0] {
    ACT_NONE, ACT_FORWARD, ACT_REFLECT, ACT_LOCAL, ACT_DROP,
    ACT_MASTER_ABORT, ACT_TARGET_ABORT, ACT_NORMAL_ONES
  } action_t;

endpackage

// ==== switch_request_route_decoder.sv ====
// request routing decision logic for a multi-port switch, with apb registers
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
`default_nettype none

module switch_request_route_decoder #(
  parameter int NPORT = 4,
  parameter int PW    = 2
) (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     reqValid,
  input  wire logic [PW-1:0]            reqPort,
  input  wire switch_route_pkg::kind_t  reqKind,
  input  wire logic                     reqPosted,
  input  wire logic                     reqCompat,
  input  wire logic [31:0]              reqAddr,
  input  wire logic [7:0]               reqBus,
  input  wire logic [4:0]               reqDev,
  output logic                          resValid,
  output switch_route_pkg::action_t     resAction,
  output logic      [PW-1:0]            resPort,
  output logic                          resToType0,
  output logic                          resClearCompat,
  output logic      [NPORT-1:0]         floodPorts,
  output logic                          fatalIrq,
  output logic                          nonfatalIrq
);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic [2:0] aPort   = paddr[7:5];
  wire logic [2:0] aReg    = paddr[4:2];
  wire logic       aHit    = (paddr[11:8] == 4'h0) && ({29'h0, aPort} < NPORT)
                             && (aReg <= switch_route_pkg::REG_STATUS);
  wire logic       access  = psel && penable && !pready;
  wire logic       wrStb   = psel && penable && pready && pwrite && aHit;
  logic [31:0]          memBase  [NPORT];
  logic [31:0]          memLimit [NPORT];
  logic [31:0]          ioRange  [NPORT];
  logic [31:0]          busCfg   [NPORT];
  logic [31:0]          ctrl     [NPORT];
  logic [5:0]           status   [NPORT];
  logic [31:0]          rdArr    [NPORT][6];
  logic [NPORT-1:0]     inRng;
  logic [NPORT-1:0]     busIn;
  logic [NPORT-1:0]     isSec;
  logic [NPORT-1:0]     masterOn;
  logic [NPORT-1:0]     serrOn;
  logic [NPORT-1:0]     nDetMa;
  logic [NPORT-1:0]     nSigTa;
  logic [NPORT-1:0]     nSigSe;
  logic [NPORT-1:0]     nSecMa;
  logic [NPORT-1:0]     nSecTa;
  logic [NPORT-1:0]     nChain;
  // ----------------------------------------
  // per port registers and hit terms
  // ----------------------------------------
  for (genvar i = 0; i < NPORT; i++)
  begin : g_port
    wire logic sel = wrStb && (aPort == 3'(i));
    wire logic [15:0] ioA = reqAddr[15:0];
    wire logic memWin = (reqAddr >= memBase[i]) && (reqAddr <= memLimit[i]);
    wire logic vgaMem = ctrl[i][switch_route_pkg::CTL_VGA_EN]
                        && (reqAddr >= switch_route_pkg::VGA_MEM_LO)
                        && (reqAddr <= switch_route_pkg::VGA_MEM_HI);
    wire logic ioWin  = (ioA >= ioRange[i][15:0]) && (ioA <= ioRange[i][31:16])
                        && !(ctrl[i][switch_route_pkg::CTL_ISA_EN]
                        && (ioA[9:8] != 2'h0));
    wire logic vgaIo  = ctrl[i][switch_route_pkg::CTL_VGA_EN]
                        && (ioA >= switch_route_pkg::VGA_IO_LO)
                        && (ioA <= switch_route_pkg::VGA_IO_HI);
    wire logic [31:0] clr = (sel && aReg == switch_route_pkg::REG_STATUS)
                            ? pwdata : 32'h0;
    wire logic [5:0] sets = {nChain[i], nSecTa[i], nSecMa[i],
                             nSigSe[i], nSigTa[i], nDetMa[i]};
    assign inRng[i] = (reqKind == switch_route_pkg::KIND_MEM) ? (memWin || vgaMem)
                                                                : (ioWin || vgaIo);
    assign busIn[i]    = (reqBus >= busCfg[i][15:8]) && (reqBus <= busCfg[i][23:16]);
    assign isSec[i]    = !ctrl[i][switch_route_pkg::CTL_PRIMARY];
    assign masterOn[i] = ctrl[i][switch_route_pkg::CTL_MASTER_EN];
    assign serrOn[i]   = ctrl[i][switch_route_pkg::CTL_SERR_EN];
    assign rdArr[i][0] = memBase[i];
    assign rdArr[i][1] = memLimit[i];
    assign rdArr[i][2] = ioRange[i];
    assign rdArr[i][3] = busCfg[i];
    assign rdArr[i][4] = ctrl[i];
    assign rdArr[i][5] = {26'h0, status[i]};
    always_ff @(posedge mclk)
    begin
      if (srst)
      begin
        memBase[i]  <= switch_route_pkg::RST_MEM_BASE;
        memLimit[i] <= switch_route_pkg::RST_MEM_LIMIT;
        ioRange[i]  <= switch_route_pkg::RST_IO_RANGE;
        busCfg[i]   <= switch_route_pkg::RST_BUS;
        ctrl[i]     <= switch_route_pkg::RST_CTRL;
        status[i]   <= 6'h0;
      end
      else
      begin
        if (sel && aReg == switch_route_pkg::REG_MEM_BASE)
          memBase[i] <= pwdata;
        if (sel && aReg == switch_route_pkg::REG_MEM_LIMIT)
          memLimit[i] <= pwdata;
        if (sel && aReg == switch_route_pkg::REG_IO_RANGE)
          ioRange[i] <= pwdata;
        if (sel && aReg == switch_route_pkg::REG_BUS)
          busCfg[i] <= {8'h0, pwdata[23:0]};
        if (sel && aReg == switch_route_pkg::REG_CTRL)
          ctrl[i] <= {4'h0, pwdata[27:0]};
        status[i] <= (status[i] & ~clr[5:0]) | sets;
      end
    end
  end
  // ----------------------------------------
  // apb response
  // ----------------------------------------
  wire logic [31:0] rdWord = aHit ? rdArr[aPort[PW-1:0]][aReg] : 32'h0;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access;
      prdata  <= (access && !pwrite) ? rdWord : 32'h0;
      pslverr <= access && !aHit;
    end
  end
  // ----------------------------------------
  // ingress port views
  // ----------------------------------------
  wire logic [31:0]   ingCtl   = ctrl[reqPort];
  wire logic [31:0]   ingBus   = busCfg[reqPort];
  wire logic [PW-1:0] dp       = ingCtl[switch_route_pkg::CTL_DEF_LSB +: PW];
  wire logic          upstream = isSec[reqPort];
  wire logic          maMode   = ingCtl[switch_route_pkg::CTL_MA_MODE];
  wire logic          devIsId  = reqDev == ingCtl[switch_route_pkg::CTL_UNIT_LSB +: 5];
  wire logic          devIsDn  = (reqDev == ingCtl[switch_route_pkg::CTL_DEV_LSB +: 5])
                                 && !ingCtl[switch_route_pkg::CTL_HOST_HIDE];
  wire logic          devInPart = {27'h0, reqDev} < NPORT;
  wire logic          spaceOn  = (reqKind == switch_route_pkg::KIND_MEM)
                                 ? ingCtl[switch_route_pkg::CTL_MEM_EN]
                                 : ingCtl[switch_route_pkg::CTL_IO_EN];
  wire logic          decodeOn = ingCtl[switch_route_pkg::CTL_DECODE_EN];
  wire logic [NPORT-1:0] dsHit = inRng & {NPORT{decodeOn && spaceOn}};
  wire logic [NPORT-1:0] usHit = inRng | ~masterOn;
  function automatic logic onlyOne(input logic [NPORT-1:0] v);
    onlyOne = (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction
  function automatic logic [PW-1:0] firstIdx(input logic [NPORT-1:0] v);
    firstIdx = '0;
    for (int k = NPORT - 1; k >= 0; k--)
      if (v[k])
        firstIdx = PW'(k);
  endfunction
  // ----------------------------------------
  // routing decision
  // ----------------------------------------
  switch_route_pkg::action_t nAct;
  logic [PW-1:0]    nPort;
  logic             nType0;
  logic             nClr;
  logic             fail;
  logic             chainErr;
  logic [NPORT-1:0] secVec;
  logic [NPORT-1:0] nFlood;
  logic             nFatal;
  logic             nNonfatal;
  wire logic [NPORT-1:0] ingBit = NPORT'(1) << reqPort;
  always_comb
  begin
    nAct     = switch_route_pkg::ACT_NONE;
    nPort    = reqPort;
    nType0   = 1'b0;
    nClr     = 1'b0;
    fail     = 1'b0;
    chainErr = 1'b0;
    secVec   = '0;
    case (reqKind)
      switch_route_pkg::KIND_MEM, switch_route_pkg::KIND_IO:
      begin
        if (!upstream)
        begin
          secVec = dsHit & isSec;
          if (reqCompat || !decodeOn)
          begin
            nAct  = switch_route_pkg::ACT_FORWARD;
            nPort = dp;
          end
          else if (!dsHit[reqPort])
          begin
            nAct     = reqPosted ? switch_route_pkg::ACT_DROP
                                 : switch_route_pkg::ACT_MASTER_ABORT;
            chainErr = reqPosted;
          end
          else if (!onlyOne(secVec))
            fail = 1'b1;
          else
          begin
            nAct  = switch_route_pkg::ACT_FORWARD;
            nPort = firstIdx(secVec);
          end
        end
        else
        begin
          secVec = usHit & isSec;
          if (usHit[reqPort])
            nAct = switch_route_pkg::ACT_REFLECT;
          else if (usHit[dp] && !onlyOne(secVec))
            fail = 1'b1;
          else if (usHit[dp])
          begin
            nAct  = switch_route_pkg::ACT_FORWARD;
            nPort = firstIdx(secVec);
            nClr  = 1'b1;
          end
          else
          begin
            nAct  = switch_route_pkg::ACT_FORWARD;
            nPort = dp;
          end
        end
      end
      switch_route_pkg::KIND_CFG0:
      begin
        if (!upstream)
          nAct = devIsId ? switch_route_pkg::ACT_LOCAL
                         : switch_route_pkg::ACT_MASTER_ABORT;
        else
          nAct = (devIsDn && ingCtl[switch_route_pkg::CTL_UP_CFG])
                 ? switch_route_pkg::ACT_LOCAL
                 : switch_route_pkg::ACT_MASTER_ABORT;
      end
      switch_route_pkg::KIND_CFG1:
      begin
        secVec = busIn & isSec;
        if (!upstream)
        begin
          if (!busIn[reqPort])
            nAct = switch_route_pkg::ACT_MASTER_ABORT;
          else if (reqBus == ingBus[15:8] && devInPart)
          begin
            nAct  = switch_route_pkg::ACT_LOCAL;
            nPort = reqDev[PW-1:0];
          end
          else if (reqBus == ingBus[15:8] || !onlyOne(secVec))
            fail = 1'b1;
          else
          begin
            nAct   = switch_route_pkg::ACT_FORWARD;
            nPort  = firstIdx(secVec);
            nType0 = reqBus == busCfg[firstIdx(secVec)][15:8];
          end
        end
        else if (!ingCtl[switch_route_pkg::CTL_UP_CFG])
          nAct = switch_route_pkg::ACT_MASTER_ABORT;
        else if (reqBus == ingBus[15:8])
        begin
          nAct   = devIsDn ? switch_route_pkg::ACT_LOCAL
                           : switch_route_pkg::ACT_REFLECT;
          nType0 = !devIsDn;
        end
        else if (busIn[reqPort])
          nAct = switch_route_pkg::ACT_REFLECT;
        else if (reqBus == ingBus[7:0])
        begin
          if (devInPart)
          begin
            nAct  = switch_route_pkg::ACT_LOCAL;
            nPort = reqDev[PW-1:0];
          end
          else
            fail = 1'b1;
        end
        else if (!busIn[dp])
        begin
          nAct  = switch_route_pkg::ACT_FORWARD;
          nPort = dp;
        end
        else if (!onlyOne(secVec))
          fail = 1'b1;
        else
        begin
          nAct   = switch_route_pkg::ACT_FORWARD;
          nPort  = firstIdx(secVec);
          nType0 = reqBus == busCfg[firstIdx(secVec)][15:8];
          nClr   = 1'b1;
        end
      end
      switch_route_pkg::KIND_MSG0:
      begin
        chainErr = upstream ? !devIsDn : !devIsId;
        nAct     = chainErr ? switch_route_pkg::ACT_DROP
                            : switch_route_pkg::ACT_LOCAL;
      end
      default:
      begin
        nAct  = switch_route_pkg::ACT_FORWARD;
        nPort = dp;
      end
    endcase
  end
  // ----------------------------------------
  // abort side effects
  // ----------------------------------------
  wire logic posted  = reqPosted && reqKind != switch_route_pkg::KIND_CFG1;
  wire logic failNp  = reqValid && fail && !posted;
  wire logic failP   = reqValid && fail && posted && maMode;
  wire logic floodOn = failP && ingCtl[switch_route_pkg::CTL_FLOOD] && serrOn[reqPort];
  wire logic vibOn   = floodOn && upstream;
  wire logic [NPORT-1:0] vibPri = {NPORT{vibOn}} & ~isSec & serrOn;
  wire logic [NPORT-1:0] vibSec = {NPORT{vibOn}} & isSec & ~ingBit;
  wire switch_route_pkg::action_t failAct =
    posted ? switch_route_pkg::ACT_DROP
           : (maMode ? switch_route_pkg::ACT_TARGET_ABORT
                     : switch_route_pkg::ACT_NORMAL_ONES);
  assign nDetMa    = (reqValid && fail && upstream) ? ingBit : '0;
  assign nSecMa    = (reqValid && fail && !upstream) ? ingBit : '0;
  assign nSigTa    = (failNp && maMode && !upstream) ? ingBit : '0;
  assign nSecTa    = (failNp && maMode && upstream) ? ingBit : '0;
  assign nSigSe    = (floodOn ? ingBit : '0) | vibPri;
  assign nFlood    = (floodOn ? ingBit : '0) | vibPri | vibSec;
  assign nChain    = (reqValid && chainErr) ? ingBit : '0;
  assign nFatal    = failP && !floodOn && ingCtl[switch_route_pkg::CTL_FATAL];
  assign nNonfatal = failP && !floodOn && !ingCtl[switch_route_pkg::CTL_FATAL]
                     && ingCtl[switch_route_pkg::CTL_NONFATAL];
  // ----------------------------------------
  // registered result
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      resValid       <= 1'b0;
      resAction      <= switch_route_pkg::ACT_NONE;
      resPort        <= '0;
      resToType0     <= 1'b0;
      resClearCompat <= 1'b0;
      floodPorts     <= '0;
      fatalIrq       <= 1'b0;
      nonfatalIrq    <= 1'b0;
    end
    else
    begin
      resValid       <= reqValid;
      resAction      <= !reqValid ? switch_route_pkg::ACT_NONE
                                  : (fail ? failAct : nAct);
      resPort        <= nPort;
      resToType0     <= reqValid && nType0;
      resClearCompat <= reqValid && nClr && reqCompat;
      floodPorts     <= nFlood;
      fatalIrq       <= nFatal;
      nonfatalIrq    <= nNonfatal;
    end
  end

endmodule

`default_nettype wire

// ==== switch_route_partner.sv ====
// request source standing in for the hosts and device chains
`timescale 1ns/100ps
`default_nettype none
module switch_route_partner #(
  parameter int PW = 2
) (
  input  wire logic               mclk,
  output logic                    reqValid,
  output logic [PW-1:0]           reqPort,
  output switch_route_pkg::kind_t reqKind,
  output logic                    reqPosted,
  output logic                    reqCompat,
  output logic [31:0]             reqAddr,
  output logic [7:0]              reqBus,
  output logic [4:0]              reqDev
);
  initial
  begin
    {reqValid, reqPort, reqPosted, reqCompat, reqAddr, reqBus, reqDev} = '0;
    reqKind = switch_route_pkg::KIND_MEM;
  end

  // one header, one cycle; address, bus and device scrambled once released
  task send(input logic [PW-1:0] p, input switch_route_pkg::kind_t k, input logic [1:0] pc,
            input logic [31:0] a, input logic [7:0] b, input logic [4:0] d);
    begin
      @(posedge mclk);
      {reqPort, reqPosted, reqCompat, reqAddr, reqBus, reqDev} <= {p, pc, a, b, d};
      reqKind <= k;
      reqValid <= 1'b1;
      @(posedge mclk);
      reqValid <= 1'b0;
      {reqAddr, reqBus, reqDev} <= ~{a, b, d};
    end
  endtask
endmodule
`default_nettype wire

// ==== switch_route_asserts.sv ====
// assertion checker for the request route decoder
`timescale 1ns/100ps
`default_nettype none
module switch_route_asserts #(
  parameter int NPORT = 4
) (
  input wire logic                      mclk,
  input wire logic                      srst,
  input wire logic                      reqValid,
  input wire switch_route_pkg::kind_t   reqKind,
  input wire logic                      reqPosted,
  input wire logic                      resValid,
  input wire switch_route_pkg::action_t resAction,
  input wire logic                      resToType0,
  input wire logic [NPORT-1:0]          floodPorts,
  input wire logic                      fatalIrq,
  input wire logic                      nonfatalIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_RES_NEXT: assert property (reqValid |=> resValid)
    else $error("result missing after header");
  AST_MSG_FWD: assert property (reqValid && reqKind inside {switch_route_pkg::KIND_INTR,
    switch_route_pkg::KIND_SMGT} |=> resAction == switch_route_pkg::ACT_FORWARD)
    else $error("message not forwarded");
  AST_NP_ANSWER: assert property (reqValid && reqKind == switch_route_pkg::KIND_MEM
    && !reqPosted |=> resAction != switch_route_pkg::ACT_DROP)
    else $error("nonposted request dropped");
  AST_P_NO_RESP: assert property (reqValid && reqKind == switch_route_pkg::KIND_MEM
    && reqPosted |=> resAction inside {switch_route_pkg::ACT_FORWARD,
    switch_route_pkg::ACT_REFLECT, switch_route_pkg::ACT_DROP})
    else $error("posted request answered");
  AST_CFG0: assert property (reqValid && reqKind == switch_route_pkg::KIND_CFG0
    |=> resAction inside {switch_route_pkg::ACT_LOCAL, switch_route_pkg::ACT_MASTER_ABORT})
    else $error("type 0 config misrouted");
  AST_MSG0: assert property (reqValid && reqKind == switch_route_pkg::KIND_MSG0
    |=> resAction inside {switch_route_pkg::ACT_LOCAL, switch_route_pkg::ACT_DROP})
    else $error("type 0 message misrouted");
  AST_FLOOD: assert property (floodPorts != '0 |-> resValid
    && resAction == switch_route_pkg::ACT_DROP ##1 (floodPorts == '0 || resValid))
    else $error("flood without drop");
  AST_IRQ: assert property (fatalIrq || nonfatalIrq |-> !(fatalIrq && nonfatalIrq)
    && resAction == switch_route_pkg::ACT_DROP)
    else $error("bad error interrupt");
  AST_TYPE0: assert property (resToType0 |-> resValid && resAction inside
    {switch_route_pkg::ACT_FORWARD, switch_route_pkg::ACT_REFLECT})
    else $error("type 0 conversion without forward");

  cover property (reqValid && reqKind == switch_route_pkg::KIND_CFG1);
  cover property (floodPorts != '0);
  cover property (fatalIrq);
endmodule

bind switch_request_route_decoder switch_route_asserts #(.NPORT(NPORT)) u_asserts (
  .mclk(mclk), .srst(srst), .reqValid(reqValid), .reqKind(reqKind), .reqPosted(reqPosted),
  .resValid(resValid), .resAction(resAction), .resToType0(resToType0),
  .floodPorts(floodPorts), .fatalIrq(fatalIrq), .nonfatalIrq(nonfatalIrq));
`default_nettype wire

// ==== switch_request_route_decoder_tb.sv ====
// self-checking bench for the request route decoder
`timescale 1ns/100ps
`default_nettype none
module switch_request_route_decoder_tb;
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr, e;
  logic        reqValid, reqPosted, reqCompat, resValid, resToType0, resClearCompat;
  logic        fatalIrq, nonfatalIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, reqAddr, rd, a;
  logic [1:0]  reqPort, resPort, ep;
  logic [7:0]  reqBus;
  logic [4:0]  reqDev;
  logic [3:0]  floodPorts;
  integer      err_count, comparisons, seed, i;
  integer      cyc = 0;
  switch_route_pkg::kind_t   reqKind;
  switch_route_pkg::action_t resAction, ea;
  localparam switch_route_pkg::kind_t KM = switch_route_pkg::KIND_MEM,
    K0 = switch_route_pkg::KIND_CFG0, K1 = switch_route_pkg::KIND_CFG1,
    KG = switch_route_pkg::KIND_MSG0, KI = switch_route_pkg::KIND_INTR;
  localparam switch_route_pkg::action_t FW = switch_route_pkg::ACT_FORWARD,
    RF = switch_route_pkg::ACT_REFLECT, LO = switch_route_pkg::ACT_LOCAL,
    DR = switch_route_pkg::ACT_DROP, MA = switch_route_pkg::ACT_MASTER_ABORT,
    TA = switch_route_pkg::ACT_TARGET_ABORT, NO = switch_route_pkg::ACT_NORMAL_ONES;
  // per port: mem base, mem limit, bus numbers, control
  logic [31:0] cfg [16] = '{32'h0, 32'h7fff, 32'h00090100, 32'h0014603f,
    32'h1000, 32'h1fff, 32'h00030201, 32'h03800474, 32'h2000, 32'h2fff, 32'h00050401,
    32'h4, 32'h2800, 32'h3fff, 32'h00070601, 32'hf0000004};

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  switch_request_route_decoder u_switch_request_route_decoder (.mclk(mclk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .reqValid(reqValid),
    .reqPort(reqPort), .reqKind(reqKind), .reqPosted(reqPosted), .reqCompat(reqCompat),
    .reqAddr(reqAddr), .reqBus(reqBus), .reqDev(reqDev), .resValid(resValid),
    .resAction(resAction), .resPort(resPort), .resToType0(resToType0),
    .resClearCompat(resClearCompat), .floodPorts(floodPorts), .fatalIrq(fatalIrq),
    .nonfatalIrq(nonfatalIrq));
  switch_route_partner u_switch_route_partner (.mclk(mclk), .reqValid(reqValid),
    .reqPort(reqPort), .reqKind(reqKind), .reqPosted(reqPosted), .reqCompat(reqCompat),
    .reqAddr(reqAddr), .reqBus(reqBus), .reqDev(reqDev));

  task tally_and_finish;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons++;
      if (seen !== exp)
      begin
        err_count++;
        $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    begin
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
        @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
    end
  endtask

  task rdchk(input logic [11:0] ad, input logic [31:0] exp, input logic experr);
    begin
      apb(1'b0, ad, 32'h0);
      chk(rd, exp);
      chk(e, experr);
    end
  endtask

  task rq(input logic [1:0] p, input switch_route_pkg::kind_t k, input logic [1:0] pc,
          input logic [31:0] ad, input logic [7:0] b, input logic [4:0] d,
          input switch_route_pkg::action_t ex, input logic [1:0] exPort);
    begin
      u_switch_route_partner.send(p, k, pc, ad, b, d);
      #1;
      chk(resValid, 1'b1);
      chk(resAction, ex);
      if (ex inside {FW, RF, LO})
        chk(resPort, exPort);
    end
  endtask

  // downstream memory from port 0 with every enable set but isa and vga
  function automatic switch_route_pkg::action_t dsExp(input logic [31:0] ad,
                                                      output logic [1:0] p);
    int h;
    begin
      h = int'(ad inside {[32'h1000:32'h1fff]}) + int'(ad inside {[32'h2000:32'h2fff]})
        + int'(ad inside {[32'h2800:32'h3fff]});
      p = (ad < 32'h2000) ? 2'h1 : (ad < 32'h2800) ? 2'h2 : 2'h3;
      return (ad > 32'h7fff) ? MA : (h == 1) ? FW : TA;
    end
  endfunction

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end

  initial
  begin
    seed = 78;
    err_count = 0;
    comparisons = 0;
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rdchk(12'h000, 32'hffffffff, 1'b0);
    rdchk(12'h008, 32'h0000ffff, 1'b0);
    rdchk(12'h010, 32'h0, 1'b0);
    rdchk(12'h100, 32'h0, 1'b1);
    for (i = 0; i < 16; i++)
      apb(1'b1, 12'(i / 4 * 32 + (i % 4 + int'(i % 4 > 1)) * 4), cfg[i]);
    rdchk(12'h070, 32'h4, 1'b0);
    for (i = 0; i < 40; i++)
    begin
      a = $random(seed) & 32'h0000ffff;
      ea = dsExp(a, ep);
      rq(2'h0, KM, 2'h0, a, 8'h0, 5'h0, ea, ep);
    end
    rq(2'h0, KM, 2'h0, 32'h5000, 8'h0, 5'h0, TA, 2'h0);
    rq(2'h0, KM, 2'h2, 32'h9000, 8'h0, 5'h0, DR, 2'h0);
    rq(2'h0, K0, 2'h0, 32'h0, 8'h0, 5'h5, LO, 2'h0);
    rq(2'h0, K0, 2'h0, 32'h0, 8'h0, 5'h6, MA, 2'h0);
    rq(2'h0, K1, 2'h0, 32'h0, 8'h2, 5'h0, FW, 2'h1);
    chk(resToType0, 1'b1);
    rq(2'h0, K1, 2'h0, 32'h0, 8'h3, 5'h0, FW, 2'h1);
    chk(resToType0, 1'b0);
    rq(2'h0, K1, 2'h0, 32'h0, 8'h14, 5'h0, MA, 2'h0);
    rq(2'h0, KG, 2'h0, 32'h0, 8'h0, 5'h6, DR, 2'h0);
    rdchk(12'h014, 32'h2a, 1'b0);
    apb(1'b1, 12'h014, 32'h2a);
    rdchk(12'h014, 32'h0, 1'b0);
    rq(2'h1, KM, 2'h0, 32'h1800, 8'h0, 5'h0, RF, 2'h1);
    rq(2'h1, KM, 2'h1, 32'h2100, 8'h0, 5'h0, FW, 2'h2);
    chk(resClearCompat, 1'b1);
    rq(2'h1, KM, 2'h0, 32'h9000, 8'h0, 5'h0, FW, 2'h0);
    rq(2'h1, KM, 2'h0, 32'h5000, 8'h0, 5'h0, TA, 2'h0);
    rq(2'h1, KM, 2'h2, 32'h2900, 8'h0, 5'h0, DR, 2'h0);
    chk(floodPorts, 4'hf);
    rq(2'h1, KI, 2'h0, 32'h0, 8'h0, 5'h0, FW, 2'h0);
    rq(2'h1, K0, 2'h0, 32'h0, 8'h0, 5'h7, LO, 2'h1);
    rq(2'h1, K1, 2'h0, 32'h0, 8'h2, 5'h7, LO, 2'h1);
    rq(2'h1, K1, 2'h0, 32'h0, 8'h3, 5'h0, RF, 2'h1);
    rq(2'h1, K1, 2'h0, 32'h0, 8'h1, 5'h2, LO, 2'h2);
    rq(2'h1, K1, 2'h0, 32'h0, 8'h4, 5'h0, FW, 2'h2);
    chk(resToType0, 1'b1);
    rq(2'h1, K1, 2'h0, 32'h0, 8'h14, 5'h0, FW, 2'h0);
    rdchk(12'h034, 32'h15, 1'b0);
    apb(1'b1, 12'h030, 32'h038000b4);
    rq(2'h1, KM, 2'h2, 32'h2900, 8'h0, 5'h0, DR, 2'h0);
    chk(fatalIrq, 1'b1);
    rq(2'h1, K0, 2'h0, 32'h0, 8'h0, 5'h7, MA, 2'h0);
    apb(1'b1, 12'h030, 32'h03800134);
    rq(2'h1, KM, 2'h2, 32'h2900, 8'h0, 5'h0, DR, 2'h0);
    chk(nonfatalIrq, 1'b1);
    chk(fatalIrq, 1'b0);
    apb(1'b1, 12'h010, 32'h0014603e);
    rq(2'h0, KM, 2'h0, 32'h1500, 8'h0, 5'h0, MA, 2'h0);
    rq(2'h0, KM, 2'h1, 32'h1500, 8'h0, 5'h0, FW, 2'h1);
    apb(1'b1, 12'h010, 32'h0014702f);
    rq(2'h0, KM, 2'h0, 32'h000a0000, 8'h0, 5'h0, NO, 2'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
